//--- design/i2sg_pkg.sv
// i2sg_pkg: offsets, field positions, reset values, states and carriers
// assumes a 32-bit classic Wishbone slave; one register per aligned word
package i2sg_pkg;
  localparam logic [7:0] CTRL_OFS  = 8'h00;
  localparam logic [7:0] BAUD_OFS  = 8'h04;
  localparam logic [7:0] STAT_OFS  = 8'h08;
  localparam logic [7:0] FLAG_OFS  = 8'h0c;
  localparam logic [7:0] MASK_OFS  = 8'h10;
  localparam logic [7:0] TXBUF_OFS = 8'h14;
  localparam int START_BIT   = 0;
  localparam int RESTART_BIT = 1;
  localparam int CTRL_LOCK_W = 5;
  localparam int BUSY_BIT    = 0;
  localparam int SEEN_BIT    = 3;
  localparam int BCOL_BIT    = 0;
  localparam int WRITE_COLLISION_FLAG_BIT    = 1;
  localparam int EVT_BIT     = 3;
  localparam logic [7:0] CTRL_RST = 8'h00;
  localparam logic [7:0] BAUD_RST = 8'h00;
  localparam logic [7:0] FLAG_RST = 8'h00;
  localparam logic [7:0] MASK_RST = 8'h00;
  localparam logic [7:0] TX_RST   = 8'h00;
  typedef enum logic [3:0] {
    ST_IDLE      = 4'h0,
    ST_S_WAIT    = 4'h1,
    ST_S_HOLD    = 4'h2,
    ST_R_SCL_LOW = 4'h3,
    ST_R_SDA_HI  = 4'h4,
    ST_R_SCL_REL = 4'h5,
    ST_R_BOTH_HI = 4'h6,
    ST_R_SDA_LOW = 4'h7
  } i2sg_state_t;
  typedef struct packed {
    logic        cyc;
    logic        stb;
    logic        we;
    logic [7:0]  adr;
    logic [3:0]  sel;
    logic [31:0] dat;
  } i2sg_wbreq_t;
  typedef struct packed {
    logic sda;
    logic scl;
  } i2sg_lines_t;
endpackage

//--- design/i2sg_start_gen.sv
// i2sg_start_gen: start / repeated start generator of a two-wire master
// assumes open-drain sda/scl with external pull-ups, Wishbone master on clk
`timescale 1ns/10ps
`default_nettype none
module i2sg_start_gen #(
  parameter int BAUD_W = 7
) (
  input  wire logic        clk,
  input  wire logic        reset_n,
  input  wire logic        wb_cyc_i,
  input  wire logic        wb_stb_i,
  input  wire logic        wb_we_i,
  input  wire logic [7:0]  wb_adr_i,
  input  wire logic [3:0]  wb_sel_i,
  input  wire logic [31:0] wb_dat_i,
  output logic      [31:0] wb_dat_o,
  output logic             wb_ack_o,
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output logic             sclOut,
  output logic             sclOe_n,
  output logic             sdaOut,
  output logic             sdaOe_n,
  output logic             irq
);
  if (BAUD_W < 7) begin : g_chk
    $error("BAUD_W must be at least 7");
  end

  function automatic logic [BAUD_W-1:0] brgLoad(input logic [7:0] rel, input logic full);
    brgLoad = full ? BAUD_W'(rel[6:0]) : BAUD_W'(rel[5:0]);
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // pin synchronisers
  i2sg_pkg::i2sg_lines_t meta_ff, sync_ff, prev_ff;
  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta_ff <= '1;
      sync_ff <= '1;
      prev_ff <= '1;
    end
    else
    begin
      meta_ff <= '{sda: sdaIn, scl: sclIn};
      sync_ff <= meta_ff;
      prev_ff <= sync_ff;
    end
  end
  logic sdaS, sclS;
  assign sdaS = sync_ff.sda;
  assign sclS = sync_ff.scl;

  ////////////////////////////////////////////////////////////////////////////
  // state
  i2sg_pkg::i2sg_wbreq_t req;
  assign req = '{cyc: wb_cyc_i, stb: wb_stb_i, we: wb_we_i, adr: wb_adr_i, sel: wb_sel_i, dat: wb_dat_i};

  i2sg_pkg::i2sg_state_t state_ff, nxt_state;
  logic [BAUD_W-1:0] cnt_ff, nxt_cnt;
  logic              run_ff, nxt_run;
  logic              sdaOeN_ff, nxt_sdaOeN;
  logic              sclOeN_ff, nxt_sclOeN;
  logic [7:0]        ctrl_ff, nxt_ctrl;
  logic [7:0]        baud_ff, nxt_baud;
  logic [7:0]        tx_ff, nxt_tx;
  logic [7:0]        flags_ff, nxt_flags;
  logic [7:0]        mask_ff, nxt_mask;
  logic              seen_ff, nxt_seen;
  logic              ack_ff, nxt_ack;
  logic [31:0]       rdat_ff, nxt_rdat;
  logic              irq_ff, nxt_irq;

  logic       tick, busy, wrEn, abort, startDet, stopDet;
  logic [7:0] evtSet, w1c;

  assign tick     = run_ff && (cnt_ff == '0);
  assign busy     = (state_ff != i2sg_pkg::ST_IDLE);
  assign wrEn     = req.cyc && req.stb && req.we && ack_ff && req.sel[0];
  assign startDet = prev_ff.sda && !sdaS && sclS;
  assign stopDet  = !prev_ff.sda && sdaS && sclS;

  always_comb
  begin
    nxt_state  = state_ff;
    nxt_cnt    = cnt_ff;
    nxt_run    = run_ff;
    nxt_sdaOeN = sdaOeN_ff;
    nxt_sclOeN = sclOeN_ff;
    nxt_ctrl   = ctrl_ff;
    nxt_baud   = baud_ff;
    nxt_tx     = tx_ff;
    nxt_mask   = mask_ff;
    evtSet     = '0;
    w1c        = '0;
    abort      = 1'b0;
    // baud generator counts down, stops at zero unless reloaded below
    if (run_ff)
    begin
      nxt_cnt = tick ? cnt_ff : cnt_ff - 1'b1;
      nxt_run = !tick;
    end
    // register writes land at the acknowledging edge
    if (wrEn && req.adr == i2sg_pkg::CTRL_OFS)
    begin
      nxt_ctrl[7:i2sg_pkg::CTRL_LOCK_W] = req.dat[7:i2sg_pkg::CTRL_LOCK_W];
      if (!busy)
        nxt_ctrl[i2sg_pkg::CTRL_LOCK_W-1:0] = req.dat[i2sg_pkg::CTRL_LOCK_W-1:0];
    end
    else if (wrEn && req.adr == i2sg_pkg::BAUD_OFS)
      nxt_baud = req.dat[7:0];
    else if (wrEn && req.adr == i2sg_pkg::TXBUF_OFS)
    begin
      if (busy)
        evtSet[i2sg_pkg::WRITE_COLLISION_FLAG_BIT] = 1'b1;
      else
        nxt_tx = req.dat[7:0];
    end
    else if (wrEn && req.adr == i2sg_pkg::FLAG_OFS)
      w1c = req.dat[7:0];
    else if (wrEn && req.adr == i2sg_pkg::MASK_OFS)
      nxt_mask = req.dat[7:0];
    case (state_ff)
      i2sg_pkg::ST_IDLE:
      begin
        if (ctrl_ff[i2sg_pkg::START_BIT])
        begin
          if (sdaS && sclS)
          begin
            nxt_cnt   = brgLoad(baud_ff, 1'b1);
            nxt_run   = 1'b1;
            nxt_state = i2sg_pkg::ST_S_WAIT;
          end
          else
            abort = 1'b1;
        end
        else if (ctrl_ff[i2sg_pkg::RESTART_BIT])
        begin
          nxt_sclOeN = 1'b0;
          nxt_state  = i2sg_pkg::ST_R_SCL_LOW;
        end
      end
      i2sg_pkg::ST_S_WAIT:
      begin
        if (!sclS || (tick && !sdaS))
          abort = 1'b1;
        else if (tick)
        begin
          nxt_sdaOeN = 1'b0;
          nxt_cnt    = brgLoad(baud_ff, 1'b1);
          nxt_run    = 1'b1;
          nxt_state  = i2sg_pkg::ST_S_HOLD;
        end
      end
      i2sg_pkg::ST_S_HOLD:
      begin
        if (tick)
        begin
          nxt_ctrl[i2sg_pkg::START_BIT] = 1'b0;
          evtSet[i2sg_pkg::EVT_BIT]     = 1'b1;
          nxt_state                     = i2sg_pkg::ST_IDLE;
        end
      end
      i2sg_pkg::ST_R_SCL_LOW:
      begin
        if (!sclS)
        begin
          nxt_cnt    = brgLoad(baud_ff, 1'b0);
          nxt_run    = 1'b1;
          nxt_sdaOeN = 1'b1;
          nxt_state  = i2sg_pkg::ST_R_SDA_HI;
        end
      end
      i2sg_pkg::ST_R_SDA_HI:
      begin
        if (tick && sdaS)
        begin
          nxt_sclOeN = 1'b1;
          nxt_state  = i2sg_pkg::ST_R_SCL_REL;
        end
        else if (tick)
          abort = 1'b1;
      end
      i2sg_pkg::ST_R_SCL_REL:
      begin
        if (sclS && !sdaS)
          abort = 1'b1;
        else if (sclS)
        begin
          nxt_cnt   = brgLoad(baud_ff, 1'b1);
          nxt_run   = 1'b1;
          nxt_state = i2sg_pkg::ST_R_BOTH_HI;
        end
      end
      i2sg_pkg::ST_R_BOTH_HI:
      begin
        if (!sclS || !sdaS)
          abort = 1'b1;
        else if (tick)
        begin
          nxt_sdaOeN = 1'b0;
          nxt_cnt    = brgLoad(baud_ff, 1'b1);
          nxt_run    = 1'b1;
          nxt_state  = i2sg_pkg::ST_R_SDA_LOW;
        end
      end
      i2sg_pkg::ST_R_SDA_LOW:
      begin
        if (tick)
        begin
          nxt_ctrl[i2sg_pkg::RESTART_BIT] = 1'b0;
          evtSet[i2sg_pkg::EVT_BIT]       = 1'b1;
          nxt_state                       = i2sg_pkg::ST_IDLE;
        end
      end
      default:
        nxt_state = i2sg_pkg::ST_IDLE;
    endcase
    if (abort)
    begin
      evtSet[i2sg_pkg::BCOL_BIT]        = 1'b1;
      nxt_ctrl[i2sg_pkg::START_BIT]     = 1'b0;
      nxt_ctrl[i2sg_pkg::RESTART_BIT]   = 1'b0;
      nxt_sdaOeN                        = 1'b1;
      nxt_sclOeN                        = 1'b1;
      nxt_run                           = 1'b0;
      nxt_state                         = i2sg_pkg::ST_IDLE;
    end
    // hardware set wins over software clear
    nxt_flags = (flags_ff & ~w1c) | evtSet;
    nxt_seen  = startDet ? 1'b1 : (stopDet ? 1'b0 : seen_ff);
    nxt_irq   = |(nxt_flags & nxt_mask);
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus answer: ack one cycle after request, dropped the cycle after
  logic [31:0] rdMux;
  always_comb
  begin
    if (req.adr == i2sg_pkg::CTRL_OFS)
      rdMux = {24'h000000, ctrl_ff};
    else if (req.adr == i2sg_pkg::BAUD_OFS)
      rdMux = {24'h000000, baud_ff};
    else if (req.adr == i2sg_pkg::STAT_OFS)
      rdMux = {28'h0000000, seen_ff, 2'b00, busy};
    else if (req.adr == i2sg_pkg::FLAG_OFS)
      rdMux = {24'h000000, flags_ff};
    else if (req.adr == i2sg_pkg::MASK_OFS)
      rdMux = {24'h000000, mask_ff};
    else if (req.adr == i2sg_pkg::TXBUF_OFS)
      rdMux = {24'h000000, tx_ff};
    else
      rdMux = 32'h00000000;
    nxt_ack  = req.cyc && req.stb && !ack_ff;
    nxt_rdat = nxt_ack ? rdMux : rdat_ff;
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      state_ff  <= i2sg_pkg::ST_IDLE;
      cnt_ff    <= '0;
      run_ff    <= 1'b0;
      sdaOeN_ff <= 1'b1;
      sclOeN_ff <= 1'b1;
      ctrl_ff   <= i2sg_pkg::CTRL_RST;
      baud_ff   <= i2sg_pkg::BAUD_RST;
      tx_ff     <= i2sg_pkg::TX_RST;
      flags_ff  <= i2sg_pkg::FLAG_RST;
      mask_ff   <= i2sg_pkg::MASK_RST;
      seen_ff   <= 1'b0;
      ack_ff    <= 1'b0;
      rdat_ff   <= 32'h00000000;
      irq_ff    <= 1'b0;
    end
    else
    begin
      state_ff  <= nxt_state;
      cnt_ff    <= nxt_cnt;
      run_ff    <= nxt_run;
      sdaOeN_ff <= nxt_sdaOeN;
      sclOeN_ff <= nxt_sclOeN;
      ctrl_ff   <= nxt_ctrl;
      baud_ff   <= nxt_baud;
      tx_ff     <= nxt_tx;
      flags_ff  <= nxt_flags;
      mask_ff   <= nxt_mask;
      seen_ff   <= nxt_seen;
      ack_ff    <= nxt_ack;
      rdat_ff   <= nxt_rdat;
      irq_ff    <= nxt_irq;
    end
  end

  // open drain: only ever pulls low
  assign sdaOut   = 1'b0;
  assign sclOut   = 1'b0;
  assign sdaOe_n  = sdaOeN_ff;
  assign sclOe_n  = sclOeN_ff;
  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdat_ff;
  assign irq      = irq_ff;

  ////////////////////////////////////////////////////////////////////////////
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!reset_n);

  property p_startLoad;
    state_ff == i2sg_pkg::ST_IDLE && ctrl_ff[i2sg_pkg::START_BIT] && sdaS && sclS
      |=> state_ff == i2sg_pkg::ST_S_WAIT && cnt_ff == BAUD_W'(baud_ff[6:0]);
  endproperty
  a_startLoad: assert property (p_startLoad) else $error("start load wrong");
  property p_startDrive;
    state_ff == i2sg_pkg::ST_S_WAIT && tick && sdaS && sclS
      |=> !sdaOe_n && state_ff == i2sg_pkg::ST_S_HOLD && run_ff;
  endproperty
  a_startDrive: assert property (p_startDrive) else $error("start drive wrong");
  property p_startDone;
    state_ff == i2sg_pkg::ST_S_HOLD && tick
      |=> state_ff == i2sg_pkg::ST_IDLE && !ctrl_ff[i2sg_pkg::START_BIT] && !sdaOe_n && !run_ff;
  endproperty
  a_startDone: assert property (p_startDone) else $error("start completion wrong");
  property p_startCol;
    state_ff == i2sg_pkg::ST_S_WAIT && !sclS
      |=> flags_ff[i2sg_pkg::BCOL_BIT] && state_ff == i2sg_pkg::ST_IDLE && sdaOe_n;
  endproperty
  a_startCol: assert property (p_startCol) else $error("start collision missed");
  property p_write_collision_flag;
    wrEn && req.adr == i2sg_pkg::TXBUF_OFS && busy
      |=> $stable(tx_ff) && flags_ff[i2sg_pkg::WRITE_COLLISION_FLAG_BIT];
  endproperty
  a_write_collision_flag: assert property (p_write_collision_flag) else $error("buffer write not dropped");
  property p_lock;
    wrEn && req.adr == i2sg_pkg::CTRL_OFS && busy && !tick && !abort
      |=> ctrl_ff[4:0] == $past(ctrl_ff[4:0]);
  endproperty
  a_lock: assert property (p_lock) else $error("control write not locked");
  property p_rsLoad;
    state_ff == i2sg_pkg::ST_R_SCL_LOW && !sclS
      |=> cnt_ff == BAUD_W'(baud_ff[5:0]) && sdaOe_n && !sclOe_n;
  endproperty
  a_rsLoad: assert property (p_rsLoad) else $error("restart load wrong");
  property p_rsRel;
    state_ff == i2sg_pkg::ST_R_SDA_HI && tick && sdaS |=> sclOe_n ##0 state_ff == i2sg_pkg::ST_R_SCL_REL;
  endproperty
  a_rsRel: assert property (p_rsRel) else $error("scl not released");
  property p_rsDone;
    state_ff == i2sg_pkg::ST_R_SDA_LOW && tick
      |=> !ctrl_ff[i2sg_pkg::RESTART_BIT] && !run_ff && !sdaOe_n && flags_ff[i2sg_pkg::EVT_BIT];
  endproperty
  a_rsDone: assert property (p_rsDone) else $error("restart completion wrong");
  property p_rsCol;
    state_ff == i2sg_pkg::ST_R_SCL_REL && sclS && !sdaS
      |=> flags_ff[i2sg_pkg::BCOL_BIT] && sdaOe_n && sclOe_n && state_ff == i2sg_pkg::ST_IDLE;
  endproperty
  a_rsCol: assert property (p_rsCol) else $error("restart collision missed");
  property p_irq;
    |(flags_ff & mask_ff) |-> irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq not raised");
  c_start: cover property (state_ff == i2sg_pkg::ST_S_HOLD && tick);
  c_restart: cover property (state_ff == i2sg_pkg::ST_R_SDA_LOW && tick);
  c_col: cover property (abort);
endmodule
`default_nettype wire

//--- test/i2sg_bus_model.sv
// i2sg_bus_model: pull-ups and a second bus party on sda/scl
// assumes open-drain ends; holdScl 1 pulls scl low, 2 clocks it from linkClk
`timescale 1ns/10ps
`default_nettype none
module i2sg_bus_model (
  input  wire logic                  linkClk,
  input  wire logic [1:0]            holdScl,
  input  wire logic                  holdSda,
  input  wire logic                  sclOut,
  input  wire logic                  sclOe_n,
  input  wire logic                  sdaOut,
  input  wire logic                  sdaOe_n,
  output wire i2sg_pkg::i2sg_lines_t lines
);
  // wired-and: released line rises by its pull-up
  assign lines.scl = (sclOe_n | sclOut) & ~((holdScl == 2'h1) | ((holdScl == 2'h2) & linkClk));
  assign lines.sda = (sdaOe_n | sdaOut) & ~holdSda;
endmodule
`default_nettype wire

//--- test/testbench.sv
// testbench: start / repeated start generator over classic Wishbone
// assumes i2sg_pkg, i2sg_start_gen and i2sg_bus_model compiled before
`timescale 1ns/10ps
`default_nettype none
module testbench;
  typedef struct packed {
    logic [7:0] ctrl;
    logic [1:0] hs;
    logic       hd;
    logic [7:0] flg;
    logic       sda;
  } i2sg_row_t;
  logic                  clk       = 1'b0;
  logic                  reset_n   = 1'b0;
  logic                  linkClk   = 1'b0;
  i2sg_pkg::i2sg_wbreq_t req       = '0;
  logic [1:0]            holdScl   = 2'h0;
  logic                  holdSda   = 1'b0;
  logic [31:0]           datO;
  logic                  ack;
  logic                  sclOut;
  logic                  sclOe_n;
  logic                  sdaOut;
  logic                  sdaOe_n;
  logic                  irq;
  i2sg_pkg::i2sg_lines_t lines;
  int                    err_total = 0;
  int                    n_tests   = 0;
  i2sg_row_t             rows [7]  = '{
    '{8'h01, 2'h0, 1'b0, 8'h01, 1'b1}, '{8'h01, 2'h0, 1'b0, 8'h08, 1'b0},
    '{8'h02, 2'h0, 1'b0, 8'h08, 1'b0}, '{8'h02, 2'h0, 1'b1, 8'h01, 1'b1},
    '{8'h01, 2'h1, 1'b0, 8'h01, 1'b1}, '{8'h01, 2'h2, 1'b0, 8'h01, 1'b1},
    '{8'h01, 2'h0, 1'b0, 8'h08, 1'b0}};
  always #5 clk = ~clk;
  always #62.5 linkClk = ~linkClk;
  i2sg_start_gen uut (.clk(clk), .reset_n(reset_n), .wb_cyc_i(req.cyc), .wb_stb_i(req.stb),
    .wb_we_i(req.we), .wb_adr_i(req.adr), .wb_sel_i(req.sel), .wb_dat_i(req.dat), .wb_dat_o(datO),
    .wb_ack_o(ack), .sclIn(lines.scl), .sdaIn(lines.sda), .sclOut(sclOut), .sclOe_n(sclOe_n),
    .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .irq(irq));
  i2sg_bus_model bus (.linkClk(linkClk), .holdScl(holdScl), .holdSda(holdSda), .sclOut(sclOut),
    .sclOe_n(sclOe_n), .sdaOut(sdaOut), .sdaOe_n(sdaOe_n), .lines(lines));
  //////////////////////////////////////////////////////////////////////////////
  task automatic complete_run;
    $display("checks %0d mismatches %0d", n_tests, err_total);
    if (err_total == 0 && n_tests > 0)
    begin
      $display("verification passed");
    end
    else
    begin
      $display("verification failed");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp)
    begin
      $display("[ERR] %0t got %h exp %h", $time, got, exp);
      err_total++;
    end
  endtask
  task automatic bus_op(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] q);
    int t;
    t = 0;
    @(posedge clk);
    req <= '{1'b1, 1'b1, w, a, 4'hf, d};
    do
    begin
      @(posedge clk);
      t++;
    end
    while (ack !== 1'b1 && t < 100);
    q = datO;
    chk({31'h0, ack}, 32'h1);
    req <= '0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    bus_op(1'b1, a, d, q);
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] q);
    bus_op(1'b0, a, 32'h0, q);
  endtask
  // polls control until both request bits have cleared
  task automatic wait_done;
    logic [31:0] q;
    int          t;
    t = 0;
    do
    begin
      rd(i2sg_pkg::CTRL_OFS, q);
      t++;
    end
    while (q[1:0] !== 2'h0 && t < 300);
    chk({30'h0, q[1:0]}, 32'h0);
  endtask
  task automatic wait_lvl(input logic onScl, input logic lvl, output int n);
    n = 0;
    while ((onScl ? sclOe_n : sdaOe_n) !== lvl && n < 2000)
    begin
      @(posedge clk);
      n++;
    end
  endtask
  task automatic do_reset;
    reset_n <= 1'b0;
    repeat (4) @(posedge clk);
    reset_n <= 1'b1;
  endtask
  //////////////////////////////////////////////////////////////////////////////
  initial
  begin
    #500us;
    err_total++;
    complete_run;
  end
  initial
  begin
    logic [31:0] q;
    int          n1;
    int          n2;
    int          m1;
    int          m2;
    do_reset;
    for (int i = 0; i < 7; i++)
    begin
      rd(8'(i * 4), q);
      chk(q, 32'h0);
    end
    wr(i2sg_pkg::BAUD_OFS, 32'h04);
    wr(i2sg_pkg::CTRL_OFS, 32'h01);
    wait_lvl(1'b0, 1'b0, n1);
    wait_done;
    do_reset;
    wr(i2sg_pkg::BAUD_OFS, 32'h0a);
    wr(i2sg_pkg::CTRL_OFS, 32'h01);
    wait_lvl(1'b0, 1'b0, n2);
    wait_done;
    chk(32'(n2 - n1), 32'h6);
    chk({31'h0, sdaOe_n}, 32'h0);
    rd(i2sg_pkg::STAT_OFS, q);
    chk({31'h0, q[i2sg_pkg::SEEN_BIT]}, 32'h1);
    rd(i2sg_pkg::FLAG_OFS, q);
    chk(q, 32'h08);
    // bit 6 of the reload must not stretch the scl-low phase
    wr(i2sg_pkg::BAUD_OFS, 32'h04);
    wr(i2sg_pkg::CTRL_OFS, 32'h02);
    wait_lvl(1'b1, 1'b0, m1);
    wait_lvl(1'b1, 1'b1, m1);
    wait_done;
    wr(i2sg_pkg::BAUD_OFS, 32'h44);
    wr(i2sg_pkg::CTRL_OFS, 32'h02);
    wait_lvl(1'b1, 1'b0, m2);
    wait_lvl(1'b1, 1'b1, m2);
    wait_done;
    chk(32'(m2), 32'(m1));
    chk({31'h0, sdaOe_n}, 32'h0);
    wr(i2sg_pkg::MASK_OFS, 32'h0b);
    wr(i2sg_pkg::FLAG_OFS, 32'hff);
    wr(i2sg_pkg::BAUD_OFS, 32'h10);
    foreach (rows[i])
    begin
      holdScl <= rows[i].hs;
      holdSda <= rows[i].hd;
      repeat (4) @(posedge clk);
      wr(i2sg_pkg::CTRL_OFS, {24'h0, rows[i].ctrl});
      wait_done;
      rd(i2sg_pkg::FLAG_OFS, q);
      chk(q, {24'h0, rows[i].flg});
      chk({31'h0, sdaOe_n}, {31'h0, rows[i].sda});
      chk({31'h0, sclOe_n}, 32'h1);
      chk({31'h0, irq}, 32'h1);
      holdScl <= 2'h0;
      holdSda <= 1'b0;
      wr(i2sg_pkg::FLAG_OFS, 32'hff);
    end
    wr(i2sg_pkg::CTRL_OFS, 32'h02);
    wr(i2sg_pkg::TXBUF_OFS, 32'h55);
    wr(i2sg_pkg::CTRL_OFS, 32'he1);
    wait_done;
    rd(i2sg_pkg::CTRL_OFS, q);
    chk(q, 32'he0);
    rd(i2sg_pkg::FLAG_OFS, q);
    chk(q, 32'h0a);
    rd(i2sg_pkg::TXBUF_OFS, q);
    chk(q, 32'h00);
    wr(i2sg_pkg::MASK_OFS, 32'h00);
    repeat (2) @(posedge clk);
    chk({31'h0, irq}, 32'h0);
    wr(i2sg_pkg::FLAG_OFS, 32'h0a);
    wr(i2sg_pkg::TXBUF_OFS, 32'ha6);
    rd(i2sg_pkg::FLAG_OFS, q);
    chk(q, 32'h00);
    rd(i2sg_pkg::TXBUF_OFS, q);
    chk(q, 32'ha6);
    complete_run;
  end
endmodule
`default_nettype wire
